/* File: bench/imr_master_rx_props.sv */
// Port checker for the master receiver
`timescale 1ns/10ps
module imr_master_rx_props
	import imr_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic scl_oe,
	input wire logic sda_oe,
	input imr_ctrl_t ctrl,
	input wire logic data_read,
	input imr_stat_t stat,
	input wire logic irq,
	input wire logic rx_valid
);
	// ========================================
	// Assertions
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_irq_gate: assert property (irq == (stat.bus_irq_flag & ctrl.bus_irq_enable))
		else $error("irq not flag and enable");
	a_start_rx: assert property (data_read && !stat.busy && !stat.transmit_select
		|=> scl_oe && stat.busy) else $error("no start on read");
	a_flag_edge: assert property ($rose(stat.bus_irq_flag)
		|-> stat.bit_counter == 3'h0 && (ctrl.wait_enable || stat.frame_end_flag))
		else $error("flag set at wrong point");
	a_wait_hold: assert property (stat.bus_irq_flag && !stat.frame_end_flag
		&& ctrl.wait_enable |=> scl_oe || !stat.bus_irq_flag) else $error("clock not held");
	a_end_flag: assert property ($rose(stat.frame_end_flag) |-> stat.bus_irq_flag)
		else $error("frame end without flag");
	a_ack_drive: assert property ($rose(sda_oe)
		|-> !ctrl.ack_data_bit && stat.bit_counter == 3'h0) else $error("bad acknowledge");
	a_count_step: assert property ($changed(stat.bit_counter)
		|-> stat.bit_counter == $past(stat.bit_counter) - 3'h1) else $error("bad count step");
	a_push_byte: assert property ($rose(rx_valid) |-> stat.bit_counter == 3'h0)
		else $error("byte pushed early");
	a_ts_defer: assert property ($rose(stat.transmit_select) && $past(stat.busy)
		|-> stat.frame_end_flag) else $error("mode switch not at frame end");
	c_hold: cover property (stat.bus_irq_flag && !stat.frame_end_flag && scl_oe);
	c_nack: cover property (stat.frame_end_flag && ctrl.ack_data_bit);
	c_full: cover property (rx_valid && scl_oe && !stat.bus_irq_flag);
endmodule : imr_master_rx_props
bind imr_master_rx imr_master_rx_props i_props (.clk, .nrst, .scl_oe, .sda_oe, .ctrl,
	.data_read, .stat, .irq, .rx_valid);

/* File: bench/imr_master_rx_tb.sv */
// Testbench of the master receiver
`timescale 1ns/10ps
module imr_master_rx_tb
	import imr_pkg::*;
;
	logic clk = 0, nrst = 0, ts_wr = 0, ts_wdata = 0, irq_clear = 0, data_read = 0;
	logic stretch = 0;
	imr_ctrl_t ctrl = '0;
	imr_stat_t stat;
	logic scl_oe, sda_oe, irq, rx_valid, s_low, d_low, ack_seen;
	logic [DATA_W-1:0] rx_data;
	int n_errors = 0;
	int tests_run = 0;
	wire scl = !(scl_oe | s_low);
	wire sda = !(sda_oe | d_low);
	always #5 clk = ~clk;
	imr_master_rx i_dut (.clk, .nrst, .scl_i(scl), .scl_o(), .scl_oe, .sda_i(sda), .sda_o(),
		.sda_oe, .ctrl, .ts_wr, .ts_wdata, .irq_clear, .data_read, .stat, .irq, .rx_valid,
		.rx_data);
	imr_slave_model i_slave (.scl, .sda, .stretch, .scl_low(s_low), .sda_low(d_low),
		.ack_seen);
	// ========================================
	// Tasks
	function automatic logic [7:0] sb(input int k);
		return 8'h96 ^ 8'(k * 8'h25);
	endfunction : sb
	task automatic close_out;
		if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : close_out
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1;
		@(negedge clk);
		s = 0;
	endtask : pulse
	task automatic await(input int w);
		for (int i = 0; i < 1000; i++) begin
			@(negedge clk);
			if ((w == 0 && stat.bus_irq_flag === 1'b1) || (w == 1 && stat.bit_counter === 3'h7)
				|| (w == 2 && stat.busy === 1'b0) || (w == 3 && stat.frame_end_flag === 1'b1))
				return;
		end
		n_errors++;
		close_out();
	endtask : await
	// ========================================
	// Sequence
	initial begin
		repeat (6) @(negedge clk);
		nrst = 1;
		pulse(ts_wr);
		pulse(irq_clear);
		ctrl.wait_enable = 1;
		ctrl.bus_irq_enable = 1;
		pulse(data_read);
		for (int k = 0; k < 3; k++) begin
			stretch = (k == 1);
			await(0);
			chk(8'(irq), 8'h01);
			chk(8'(stat.frame_end_flag), 8'h00);
			repeat (30) @(negedge clk);
			chk(8'({scl_oe, scl}), 8'h02);
			chk(rx_data, sb(k));
			pulse(irq_clear);
			await(3);
			chk(8'(stat.bus_irq_flag), 8'h01);
			chk(8'(ack_seen), 8'(k == 2));
			if (k < 2) await(1);
			pulse(data_read);
			pulse(irq_clear);
			if (k == 1) begin
				ctrl.ack_data_bit = 1;
				ts_wdata = 1;
				pulse(ts_wr);
				chk(8'(stat.transmit_select), 8'h00);
			end
		end
		await(2);
		chk(8'({stat.transmit_select, stat.busy, rx_valid}), 8'h04);
		nrst = 0;
		repeat (3) @(negedge clk);
		nrst = 1;
		chk(8'(stat), 8'h00);
		chk(8'({irq, scl_oe, sda_oe, rx_valid}), 8'h00);
		ctrl = '0;
		pulse(data_read);
		repeat (400) @(negedge clk);
		chk(8'({irq, stat.frame_end_flag}), 8'h01);
		chk(8'({scl_oe, stat.bit_counter}), 8'h08);
		chk(rx_data, sb(3));
		pulse(ts_wr);
		pulse(data_read);
		chk(rx_data, sb(4));
		await(2);
		pulse(data_read);
		chk(rx_data, sb(5));
		close_out();
	end
endmodule : imr_master_rx_tb

/* File: bench/imr_slave_model.sv */
// Slave device model sending bytes on the data line
`timescale 1ns/10ps
module imr_slave_model (
	input wire logic scl,
	input wire logic sda,
	input wire logic stretch,
	output logic scl_low,
	output logic sda_low,
	output logic ack_seen
);
	int cnt = 8;
	int nf = 0;
	logic [7:0] b = 8'h00;
	initial begin
		scl_low = 0;
		sda_low = 0;
		ack_seen = 1;
	end
	// ========================================
	// Data after each falling edge but every ninth (acknowledge slot, sda released), MSB first
	always @(negedge scl) begin
		cnt = (cnt == 8) ? 0 : cnt + 1;
		if (cnt == 0) begin
			b = 8'h96 ^ 8'(nf * 8'h25);
			nf++;
		end
		sda_low = (cnt < 8) ? !b[7 - cnt] : 1'b0;
		if (stretch) begin
			scl_low = 1;
			#150;
			scl_low = 0;
		end
	end
	always @(posedge scl) if (cnt == 8) ack_seen = sda;
endmodule : imr_slave_model

/* File: rtl/imr_master_rx.sv */
// Two-wire bus master receiver with wait insertion
`timescale 1ns/10ps
module imr_master_rx
	import imr_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input imr_ctrl_t ctrl,
	input wire logic ts_wr,
	input wire logic ts_wdata,
	input wire logic irq_clear,
	input wire logic data_read,
	output imr_stat_t stat,
	output logic irq,
	output logic rx_valid,
	output logic [DATA_W-1:0] rx_data
);

	imr_state_t state_ff;
	imr_state_t nxt_state;
	logic [HALF_W-1:0] cnt_ff;
	logic [HALF_W-1:0] nxt_cnt;
	logic [2:0] bc_ff;
	logic [DATA_W-1:0] shreg_ff;
	logic scl_s1_ff;
	logic scl_s2_ff;
	logic scl_s3_ff;
	logic sda_s1_ff;
	logic sda_s2_ff;
	logic scl_rise;
	logic flag_ff;
	logic frame_end_ff;
	logic ts_ff;
	logic ts_pend_ff;
	logic ack_ff;
	logic scl_oe_ff;
	logic sda_oe_ff;
	logic buf_in_valid;
	logic buf_in_ready;
	logic start_rx;
	logic cnt_done;
	logic set8;
	logic set9;
	logic push_byte;
	logic wait_release;
	logic enter_ack;
	logic drive_ack;
	logic nxt_scl_oe;
	logic nxt_sda_oe;

	// ==========================================
	// Pin synchronisers
	always_ff @(posedge clk) begin
		if (!nrst) begin
			scl_s1_ff <= 1'b1;
			scl_s2_ff <= 1'b1;
			scl_s3_ff <= 1'b1;
			sda_s1_ff <= 1'b1;
			sda_s2_ff <= 1'b1;
		end else begin
			scl_s1_ff <= scl_i;
			scl_s2_ff <= scl_s1_ff;
			scl_s3_ff <= scl_s2_ff;
			sda_s1_ff <= sda_i;
			sda_s2_ff <= sda_s1_ff;
		end
	end

	assign scl_rise = scl_s2_ff && !scl_s3_ff;

	// ==========================================
	// Control decode
	assign cnt_done = (cnt_ff == '0);
	assign start_rx = data_read && (state_ff == ST_IDLE) && !ts_ff;
	assign push_byte = (state_ff == ST_DHIGH) && cnt_done && (bc_ff == BC_RESET);
	assign set8 = push_byte && ctrl.wait_enable;
	assign set9 = (state_ff == ST_AWAIT) && scl_rise;
	assign buf_in_valid = push_byte;
	assign wait_release = (state_ff == ST_HOLD) && !flag_ff;

	// ==========================================
	// Sequencer
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		case (state_ff)
			ST_IDLE: begin
				if (start_rx) begin
					nxt_state = ST_DLOW;
					nxt_cnt = SCL_HALF_CYC;
				end
			end
			ST_DLOW: begin
				// No new frame until the buffer has room
				if (bc_ff != BC_RESET || buf_in_ready) begin
					if (cnt_done) begin
						nxt_state = ST_DWAIT;
					end else begin
						nxt_cnt = cnt_ff - 1'b1;
					end
				end
			end
			ST_DWAIT: begin
				if (scl_rise) begin
					nxt_state = ST_DHIGH;
					nxt_cnt = SCL_HALF_CYC;
				end
			end
			ST_DHIGH: begin
				if (cnt_done) begin
					nxt_cnt = SCL_HALF_CYC;
					if (bc_ff != BC_RESET) begin
						nxt_state = ST_DLOW;
					end else if (ctrl.wait_enable) begin
						nxt_state = ST_HOLD;
					end else begin
						nxt_state = ST_ALOW;
					end
				end else begin
					nxt_cnt = cnt_ff - 1'b1;
				end
			end
			ST_HOLD: begin
				if (wait_release) begin
					nxt_state = ST_ALOW;
					nxt_cnt = SCL_HALF_CYC;
				end
			end
			ST_ALOW: begin
				if (cnt_done) begin
					nxt_state = ST_AWAIT;
				end else begin
					nxt_cnt = cnt_ff - 1'b1;
				end
			end
			ST_AWAIT: begin
				if (scl_rise) begin
					nxt_state = ST_AHIGH;
					nxt_cnt = SCL_HALF_CYC;
				end
			end
			ST_AHIGH: begin
				if (cnt_done) begin
					nxt_cnt = SCL_HALF_CYC;
					nxt_state = ts_ff ? ST_IDLE : ST_DLOW;
				end else begin
					nxt_cnt = cnt_ff - 1'b1;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
				nxt_cnt = '0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_ff <= ST_IDLE;
			cnt_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
		end
	end

	// ==========================================
	// Bit counter and shift register
	always_ff @(posedge clk) begin
		if (!nrst) begin
			bc_ff <= BC_RESET;
			shreg_ff <= DATA_RESET;
		end else if (state_ff == ST_DWAIT && scl_rise) begin
			bc_ff <= bc_ff - 1'b1;
			shreg_ff <= {shreg_ff[DATA_W-2:0], sda_s2_ff};
		end
	end

	// ==========================================
	// Interrupt flag and frame end flag
	always_ff @(posedge clk) begin
		if (!nrst) begin
			flag_ff <= 1'b0;
		end else if (set8 || set9) begin
			flag_ff <= 1'b1;
		end else if (irq_clear) begin
			flag_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			frame_end_ff <= 1'b0;
		end else if (set9) begin
			frame_end_ff <= 1'b1;
		end else if (irq_clear) begin
			frame_end_ff <= 1'b0;
		end
	end

	assign irq = flag_ff && ctrl.bus_irq_enable;

	// ==========================================
	// Transmit select with deferred set
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ts_ff <= 1'b0;
			ts_pend_ff <= 1'b0;
		end else begin
			if (ts_wr && ts_wdata && state_ff != ST_IDLE) begin
				ts_pend_ff <= 1'b1;
			end else if (ts_wr) begin
				ts_ff <= ts_wdata;
				ts_pend_ff <= 1'b0;
			end
			if (set9 && (ts_pend_ff || (ts_wr && ts_wdata))) begin
				ts_ff <= 1'b1;
				ts_pend_ff <= 1'b0;
			end
		end
	end

	// ==========================================
	// Acknowledge capture
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ack_ff <= 1'b1;
		end else if (enter_ack) begin
			ack_ff <= ctrl.ack_data_bit;
		end
	end

	// ==========================================
	// Pin driver decode
	always_comb begin
		enter_ack = (nxt_state == ST_ALOW) && (state_ff != ST_ALOW);
		drive_ack = enter_ack ? !ctrl.ack_data_bit : !ack_ff;
		nxt_scl_oe = 1'b0;
		nxt_sda_oe = 1'b0;
		case (nxt_state)
			ST_DLOW, ST_HOLD: begin
				nxt_scl_oe = 1'b1;
			end
			ST_ALOW: begin
				nxt_scl_oe = 1'b1;
				nxt_sda_oe = drive_ack;
			end
			ST_AWAIT, ST_AHIGH: begin
				nxt_sda_oe = drive_ack;
			end
			default: begin
				nxt_scl_oe = 1'b0;
				nxt_sda_oe = 1'b0;
			end
		endcase
	end

	// ==========================================
	// Pin drivers
	always_ff @(posedge clk) begin
		if (!nrst) begin
			scl_oe_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
		end else begin
			scl_oe_ff <= nxt_scl_oe;
			sda_oe_ff <= nxt_sda_oe;
		end
	end

	assign scl_oe = scl_oe_ff;
	assign scl_o = 1'b0;
	assign sda_oe = sda_oe_ff;
	assign sda_o = 1'b0;

	// ==========================================
	// Received data buffer
	imr_rx_buf #(
		.WIDTH(DATA_W),
		.DEPTH(BUF_DEPTH)
	) u_rx_buf (
		.clk(clk),
		.nrst(nrst),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.in_data(shreg_ff),
		.out_valid(rx_valid),
		.out_ready(data_read),
		.out_data(rx_data)
	);

	// ==========================================
	// Status
	assign stat.bus_irq_flag = flag_ff;
	assign stat.frame_end_flag = frame_end_ff;
	assign stat.bit_counter = bc_ff;
	assign stat.transmit_select = ts_ff;
	assign stat.busy = (state_ff != ST_IDLE);

endmodule : imr_master_rx

/* File: rtl/imr_pkg.sv */
// Package of constants and types for the master receive block with wait insertion
package imr_pkg;

	// ==========================================
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCL_HALF_NS = 40;
	localparam int SCL_HALF_CYC_I = (SCL_HALF_NS / CLK_PERIOD_NS) < 1 ? 1 :
		(SCL_HALF_NS / CLK_PERIOD_NS);
	localparam int HALF_W = 4;
	localparam logic [HALF_W-1:0] SCL_HALF_CYC = HALF_W'(SCL_HALF_CYC_I - 1);

	// ==========================================
	// Widths and reset values
	localparam int DATA_W = 8;
	localparam int BUF_DEPTH = 2;
	localparam logic [2:0] BC_RESET = 3'h0;
	localparam logic [2:0] BC_LAST = 3'h1;
	localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

	// ==========================================
	// Types
	typedef enum logic [7:0] {
		ST_IDLE  = 8'b0000_0001,
		ST_DLOW  = 8'b0000_0010,
		ST_DWAIT = 8'b0000_0100,
		ST_DHIGH = 8'b0000_1000,
		ST_HOLD  = 8'b0001_0000,
		ST_ALOW  = 8'b0010_0000,
		ST_AWAIT = 8'b0100_0000,
		ST_AHIGH = 8'b1000_0000
	} imr_state_t;

	typedef struct packed {
		logic ack_data_bit;
		logic wait_enable;
		logic bus_irq_enable;
	} imr_ctrl_t;

	typedef struct packed {
		logic bus_irq_flag;
		logic frame_end_flag;
		logic [2:0] bit_counter;
		logic transmit_select;
		logic busy;
	} imr_stat_t;

endpackage : imr_pkg

/* File: rtl/imr_rx_buf.sv */
// Two-entry receive buffer with valid and ready on both sides
`timescale 1ns/10ps
module imr_rx_buf
	import imr_pkg::*;
#(
	parameter int WIDTH = DATA_W,
	parameter int DEPTH = BUF_DEPTH
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [PW-1:0] wr_ptr_ff;
	logic [PW-1:0] rd_ptr_ff;
	logic [PW:0] count_ff;
	logic push;
	logic pop;

	// ==========================================
	// Handshake
	assign in_ready = (count_ff != (PW+1)'(DEPTH));
	assign out_valid = (count_ff != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_ff[rd_ptr_ff];

	// ==========================================
	// Storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
			end
			if (push && !pop) begin
				count_ff <= count_ff + 1'b1;
			end else if (pop && !push) begin
				count_ff <= count_ff - 1'b1;
			end
		end
	end

endmodule : imr_rx_buf
